// >>> hw/ssp_pkg.sv
// constants, types and register map of the step-rate profiler
package ssp_pkg;

  // clock and time base
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_TIME_NS = 1_000_000;
  localparam int MS_CYC = MS_TIME_NS / CLK_PERIOD_NS;
  localparam logic [25:0] CLK_HZ_W = 26'(CLK_HZ);

  // minimum rate in pulses per second and its period in clock cycles
  localparam logic [15:0] MIN_RATE = 16'h003E;
  localparam logic [25:0] PER_MIN = 26'(CLK_HZ / 62);

  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] TARGET_OFF = 8'h04;
  localparam logic [7:0] ACCEL_OFF = 8'h08;
  localparam logic [7:0] TBASE_OFF = 8'h0C;
  localparam logic [7:0] CMD_OFF = 8'h10;
  localparam logic [7:0] COUNT_OFF = 8'h14;
  localparam logic [7:0] STATUS_OFF = 8'h18;
  localparam logic [7:0] REMAIN_OFF = 8'h1C;

  // command bit positions
  localparam int CMD_TOGGLE = 0;
  localparam int CMD_SINGLE = 1;
  localparam int CMD_MOVE = 2;
  localparam int CMD_UPDATE = 3;

  // status field positions
  localparam int ST_LSB = 0;
  localparam int RATE_LSB = 16;

  // values after reset
  localparam logic [7:0] CTRL_RST = 8'h41;
  localparam logic [15:0] TARGET_RST = 16'h0064;
  localparam logic [7:0] ACCEL_RST = 8'h00;
  localparam logic [7:0] TBASE_RST = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;

  typedef struct packed {
    logic step_level;
    logic sync_rectify_low;
    logic microstep_sel1;
    logic microstep_sel0;
    logic dir;
    logic chip_clear_low;
    logic standby_low;
    logic bridge_on_low;
  } ssp_ctrl_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RUN = 3'b001,
    ST_STOP = 3'b010,
    ST_MOVE = 3'b011
  } ssp_state_e;

endpackage

// >>> hw/ssp_profiler.sv
// step-rate profiler: ramped runs, counted moves, single steps
// Summary of operation
// - every continuous run starts at 62 pulses per second
// - each rate change in a run moves the present rate by the 8-bit increment toward the target, or onto the target when it is nearer
// - rate changes are spaced by the 8-bit time base in milliseconds
// - rate holds once it reaches the target
// - stop ramps down by the same increment and time base, then ceases
// - one shared increment and time base serve both ramps
// - toggle command starts continuous stepping, second toggle stops it
// - new target taken while running, refused while halted
// - single-step command issues exactly one step pulse
// - driver steps on rising edge; host may set step line directly
// - counted move emits 0 to 65535 pulses at target rate, then stops
// - counted move runs at constant rate with no ramp
`timescale 1ns/1ps
module ssp_profiler
  import ssp_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC
)
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic bridge_on_low_o,
  output logic standby_low_o,
  output logic chip_clear_low_o,
  output logic dir_o,
  output logic microstep_sel0_o,
  output logic microstep_sel1_o,
  output logic sync_rectify_low_o,
  output logic step_o
);

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [15:0] clamp_rate(input logic [15:0] v);
    clamp_rate = (v < MIN_RATE) ? MIN_RATE : v;
  endfunction

  ssp_ctrl_s ctrl_r;
  logic [15:0] target_r;
  logic [7:0] accel_r;
  logic [7:0] tbase_r;
  logic [15:0] count_r;
  ssp_state_e state_r;
  logic [15:0] rate_r;
  logic [15:0] tgt_live_r;
  logic [15:0] left_r;
  logic fin_r;
  logic [15:0] ms_cnt_r;
  logic [7:0] tb_cnt_r;
  logic [15:0] div_rate_r;
  logic [15:0] div_den_r;
  logic [15:0] div_rem_r;
  logic [25:0] div_quo_r;
  logic [4:0] div_idx_r;
  logic div_busy_r;
  logic [25:0] per_new_r;
  logic per_ok_r;
  logic [25:0] per_act_r;
  logic [25:0] ph_cnt_r;

  logic cmd_wr;
  logic start_run;
  logic start_single;
  logic start_move;
  logic stop_req;
  logic upd_req;
  logic ramping;
  logic ms_tick;
  logic chg_now;
  logic gen_on;
  logic wrap;
  logic stop_last;
  logic [25:0] hi_len;
  logic [16:0] up_sum;
  logic [16:0] rem_sh;
  logic rem_ge;
  logic div_done;
  logic [25:0] div_res;

  // command decode: toggle wins over move, move over single
  assign cmd_wr = ce_i && wr_i && hit(addr_i, CMD_OFF);
  assign start_run = cmd_wr && wdata_i[CMD_TOGGLE]
                     && (state_r == ST_IDLE);
  assign stop_req = cmd_wr && wdata_i[CMD_TOGGLE] && (state_r == ST_RUN);
  assign start_move = cmd_wr && !wdata_i[CMD_TOGGLE] && wdata_i[CMD_MOVE]
                      && (state_r == ST_IDLE) && (count_r != 16'h0000);
  assign start_single = cmd_wr && !wdata_i[CMD_TOGGLE]
                        && !wdata_i[CMD_MOVE] && wdata_i[CMD_SINGLE]
                        && (state_r == ST_IDLE);
  assign upd_req = cmd_wr && wdata_i[CMD_UPDATE] && (state_r == ST_RUN);

  assign ramping = (state_r == ST_RUN) || (state_r == ST_STOP);
  assign ms_tick = ramping && (ms_cnt_r == 16'(MS_CYCLES - 1));
  // time base 0 and 1 both give one change per millisecond
  assign chg_now = ms_tick
                   && ({1'b0, tb_cnt_r} + 9'h001 >= {1'b0, tbase_r});
  assign up_sum = {1'b0, rate_r} + {9'h000, accel_r};
  assign stop_last = (accel_r == 8'h00)
                     || ({1'b0, rate_r} <= {1'b0, MIN_RATE}
                         + {9'h000, accel_r});

  assign gen_on = (state_r != ST_IDLE) && per_ok_r;
  assign wrap = gen_on && (ph_cnt_r == per_act_r - 26'h0000001);
  assign hi_len = per_act_r - (per_act_r >> 1);

  assign rem_sh = {div_rem_r, CLK_HZ_W[div_idx_r]};
  assign rem_ge = (rem_sh >= {1'b0, div_den_r});
  assign div_done = div_busy_r && (div_idx_r == 5'h00);
  assign div_res = {div_quo_r[24:0], rem_ge};

  // register writes
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= ssp_ctrl_s'(CTRL_RST);
      target_r <= TARGET_RST;
      accel_r <= ACCEL_RST;
      tbase_r <= TBASE_RST;
      count_r <= COUNT_RST;
    end
    else if (ce_i && wr_i)
    begin
      // pin levels are the host's to set before any stepping
      if (hit(addr_i, CTRL_OFF))
        ctrl_r <= ssp_ctrl_s'(wdata_i[7:0]);
      if (hit(addr_i, TARGET_OFF))
        target_r <= wdata_i[15:0];
      // one increment and one time base for both ramps
      if (hit(addr_i, ACCEL_OFF))
        accel_r <= wdata_i[7:0];
      if (hit(addr_i, TBASE_OFF))
        tbase_r <= wdata_i[7:0];
      if (hit(addr_i, COUNT_OFF))
        count_r <= wdata_i[15:0];
    end
  end

  // read port: data valid only in the cycle after the strobe
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= 32'h0000_0000;
    else if (ce_i)
    begin
      rdata_o <= 32'h0000_0000;
      if (rd_i)
      begin
        if (hit(addr_i, CTRL_OFF))
          rdata_o <= {24'h000000, ctrl_r};
        else if (hit(addr_i, TARGET_OFF))
          rdata_o <= {16'h0000, target_r};
        else if (hit(addr_i, ACCEL_OFF))
          rdata_o <= {24'h000000, accel_r};
        else if (hit(addr_i, TBASE_OFF))
          rdata_o <= {24'h000000, tbase_r};
        else if (hit(addr_i, COUNT_OFF))
          rdata_o <= {16'h0000, count_r};
        else if (hit(addr_i, STATUS_OFF))
          rdata_o <= {rate_r, 13'h0000, state_r};
        else if (hit(addr_i, REMAIN_OFF))
          rdata_o <= {16'h0000, left_r};
      end
    end
  end

  // millisecond tick and time-base interval
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ms_cnt_r <= 16'h0000;
      tb_cnt_r <= 8'h00;
    end
    else if (ce_i)
    begin
      if (!ramping)
      begin
        ms_cnt_r <= 16'h0000;
        tb_cnt_r <= 8'h00;
      end
      else if (ms_tick)
      begin
        ms_cnt_r <= 16'h0000;
        tb_cnt_r <= chg_now ? 8'h00 : tb_cnt_r + 8'h01;
      end
      else
        ms_cnt_r <= ms_cnt_r + 16'h0001;
    end
  end

  // motion sequencer
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_IDLE;
      rate_r <= MIN_RATE;
      tgt_live_r <= MIN_RATE;
      left_r <= 16'h0000;
      fin_r <= 1'b0;
    end
    else if (ce_i)
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          fin_r <= 1'b0;
          if (start_run)
          begin
            state_r <= ST_RUN;
            rate_r <= MIN_RATE;
            tgt_live_r <= clamp_rate(target_r);
          end
          else if (start_move)
          begin
            state_r <= ST_MOVE;
            rate_r <= clamp_rate(target_r);
            left_r <= count_r;
          end
          else if (start_single)
          begin
            state_r <= ST_MOVE;
            rate_r <= MIN_RATE;
            left_r <= 16'h0001;
          end
        end
        ST_RUN:
        begin
          if (stop_req)
            state_r <= ST_STOP;
          if (upd_req)
            tgt_live_r <= clamp_rate(target_r);
          if (chg_now && !stop_req)
          begin
            if (rate_r < tgt_live_r)
              rate_r <= (up_sum >= {1'b0, tgt_live_r}) ? tgt_live_r
                        : up_sum[15:0];
            else if (rate_r > tgt_live_r)
              rate_r <= (rate_r - tgt_live_r <= {8'h00, accel_r})
                        ? tgt_live_r : rate_r - {8'h00, accel_r};
          end
        end
        ST_STOP:
        begin
          if (chg_now && !fin_r)
          begin
            if (stop_last)
            begin
              fin_r <= 1'b1;
              rate_r <= MIN_RATE;
            end
            else
              rate_r <= rate_r - {8'h00, accel_r};
          end
          // cease on a period boundary so the last pulse is whole
          if (fin_r && wrap)
            state_r <= ST_IDLE;
        end
        ST_MOVE:
        begin
          // rate_r is left alone here: no ramp in a counted move
          if (wrap)
          begin
            left_r <= left_r - 16'h0001;
            if (left_r == 16'h0001)
              state_r <= ST_IDLE;
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // period divider: clock rate over pulse rate, restoring, 26 cycles
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      div_rate_r <= MIN_RATE;
      div_den_r <= MIN_RATE;
      div_rem_r <= 16'h0000;
      div_quo_r <= 26'h0000000;
      div_idx_r <= 5'h00;
      div_busy_r <= 1'b0;
      per_new_r <= PER_MIN;
      per_ok_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (start_run || start_single)
      begin
        div_busy_r <= 1'b0;
        div_rate_r <= MIN_RATE;
        per_new_r <= PER_MIN;
        per_ok_r <= 1'b1;
      end
      else if (start_move)
      begin
        // zero never matches a clamped rate, so a divide always follows
        div_busy_r <= 1'b0;
        div_rate_r <= 16'h0000;
        per_ok_r <= 1'b0;
      end
      else if (div_busy_r)
      begin
        div_rem_r <= rem_ge ? 16'(rem_sh - {1'b0, div_den_r})
                     : rem_sh[15:0];
        div_quo_r <= {div_quo_r[24:0], rem_ge};
        div_idx_r <= div_idx_r - 5'h01;
        if (div_idx_r == 5'h00)
        begin
          div_busy_r <= 1'b0;
          per_new_r <= {div_quo_r[24:0], rem_ge};
          per_ok_r <= 1'b1;
        end
      end
      else if (rate_r != div_rate_r)
      begin
        div_busy_r <= 1'b1;
        div_rate_r <= rate_r;
        div_den_r <= rate_r;
        div_rem_r <= 16'h0000;
        div_quo_r <= 26'h0000000;
        div_idx_r <= 5'h19;
      end
    end
  end

  // pulse generator; a new period takes effect at the next boundary
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ph_cnt_r <= 26'h0000000;
      per_act_r <= PER_MIN;
      step_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!gen_on)
      begin
        ph_cnt_r <= 26'h0000000;
        // first pulse must not inherit a stale period from the last motion
        if (start_run || start_single)
          per_act_r <= PER_MIN;
        else if (div_done)
          per_act_r <= div_res;
        else
          per_act_r <= per_new_r;
        step_o <= ctrl_r.step_level;
      end
      else
      begin
        if (wrap)
        begin
          ph_cnt_r <= 26'h0000000;
          per_act_r <= per_new_r;
        end
        else
          ph_cnt_r <= ph_cnt_r + 26'h0000001;
        step_o <= (ph_cnt_r < hi_len);
      end
    end
  end

  // driver control pins straight from the control register
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bridge_on_low_o <= CTRL_RST[0];
      standby_low_o <= CTRL_RST[1];
      chip_clear_low_o <= CTRL_RST[2];
      dir_o <= CTRL_RST[3];
      microstep_sel0_o <= CTRL_RST[4];
      microstep_sel1_o <= CTRL_RST[5];
      sync_rectify_low_o <= CTRL_RST[6];
    end
    else if (ce_i)
    begin
      bridge_on_low_o <= ctrl_r.bridge_on_low;
      standby_low_o <= ctrl_r.standby_low;
      chip_clear_low_o <= ctrl_r.chip_clear_low;
      dir_o <= ctrl_r.dir;
      microstep_sel0_o <= ctrl_r.microstep_sel0;
      microstep_sel1_o <= ctrl_r.microstep_sel1;
      sync_rectify_low_o <= ctrl_r.sync_rectify_low;
    end
  end

  a_start_min_rate: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    start_run |=> (rate_r == MIN_RATE) && (state_r == ST_RUN))
    else $error("run did not start at minimum rate");

  a_ramp_up_add: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    ce_i && chg_now && (state_r == ST_RUN) && !stop_req
    && (up_sum < {1'b0, tgt_live_r})
    |=> rate_r == $past(rate_r) + {8'h00, $past(accel_r)})
    else $error("ramp step not equal to increment");

  a_change_spacing: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    ce_i && (state_r == ST_RUN) && !chg_now && !upd_req
    |=> $stable(rate_r))
    else $error("rate changed outside a time-base instant");

  a_hold_target: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    ce_i && (state_r == ST_RUN) && (rate_r == tgt_live_r) && !stop_req
    |=> rate_r == $past(tgt_live_r))
    else $error("rate left target");

  a_stop_ramp_down: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    ce_i && (state_r == ST_STOP) && chg_now && !fin_r && !stop_last
    |=> rate_r == $past(rate_r) - {8'h00, $past(accel_r)})
    else $error("stop ramp step wrong");

  a_refuse_update: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    ce_i && cmd_wr && wdata_i[CMD_UPDATE] && (state_r != ST_RUN)
    && !start_run |=> $stable(tgt_live_r))
    else $error("target taken while halted");

  a_single_one: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    start_single |=> (state_r == ST_MOVE) && (left_r == 16'h0001))
    else $error("single step not one pulse");

  a_move_done: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    ce_i && (state_r == ST_MOVE) && wrap && (left_r == 16'h0001)
    |=> state_r == ST_IDLE)
    else $error("move did not stop after last pulse");

  a_move_constant: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (state_r == ST_MOVE) && ($past(state_r) == ST_MOVE) |-> $stable(rate_r))
    else $error("rate changed during counted move");

  a_pulse_high: assert property (
    @(posedge mclk_i) disable iff (rst_i || !ce_i)
    ce_i && gen_on && (ph_cnt_r == 26'h0000000) |=> step_o [*8])
    else $error("step pulse too short");

endmodule // ssp_profiler

// >>> testbench/ssp_drv_model.sv
// behavioural model of the stepper driver's control inputs
`timescale 1ns/1ps
module ssp_drv_model
(
  input wire logic bridge_on_low_i,
  input wire logic standby_low_i,
  input wire logic chip_clear_low_i,
  input wire logic dir_i,
  input wire logic sync_rectify_low_i,
  input wire logic step_i,
  output wire logic [31:0] steps_o,
  output wire logic [31:0] position_o,
  output wire logic [31:0] faults_o
);
  logic live;
  logic [31:0] steps_q = 32'h0;
  logic [31:0] pos_q = 32'h0;
  logic [31:0] faults_q = 32'h0;

  assign steps_o = steps_q;
  assign position_o = pos_q;
  assign faults_o = faults_q;

  // bridges only move while enabled, awake and out of clear
  assign live = !bridge_on_low_i && standby_low_i && chip_clear_low_i;

  // one microstep per rising step edge; levels read just after it,
  // since control pins and step may switch on the same clock edge
  always @(posedge step_i)
  begin
    #1;
    if (live)
    begin
      steps_q <= steps_q + 1;
      pos_q <= dir_i ? pos_q + 1 : pos_q - 1;
      // board has no flyback diodes: stepping needs sync rectify on
      if (sync_rectify_low_i)
        faults_q <= faults_q + 1;
    end
  end
endmodule // ssp_drv_model

// >>> testbench/ssp_profiler_bench.sv
// self-checking bench of the step-rate profiler
`timescale 1ns/1ps
module ssp_profiler_bench;
  import ssp_pkg::*;
  localparam int MSC = 20;
  localparam int TB = 2;
  localparam logic [7:0] RA [10] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h08,
    8'h0C, 8'h14, 8'h20, 8'h18, 8'h10};
  localparam logic [31:0] RD [10] = '{32'hBE, 32'h3E, 32'h30, 32'h1234,
    32'h1FF, 32'h103, 32'h10005, 32'hFFFF, 32'h7, 32'h0};
  localparam logic [31:0] RE [10] = '{32'hBE, 32'h3E, 32'h30, 32'h1234,
    32'hFF, 32'h03, 32'h05, 32'h0, 32'h003E_0000, 32'h0};
  localparam logic [31:0] RV [8] = '{32'h41, 32'h64, 0, 0, 0, 0, 0, 0};
  logic mclk_i = 0;
  logic rst_i = 1;
  logic ce_i = 1;
  logic wr_i = 0;
  logic rd_i = 0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic [31:0] rdata_o, d, base;
  logic bon, sby, clr, dir, ms0, ms1, srl, step;
  logic [31:0] steps, pos, faults;
  logic [7:0] ctrl;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  int hi, per, k;
  wire logic [7:0] pins = {step, srl, ms1, ms0, dir, clr, sby, bon};

  always #12.5 mclk_i = ~mclk_i;

  ssp_profiler #(.MS_CYCLES(MSC)) dut (.mclk_i(mclk_i), .rst_i(rst_i),
    .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .bridge_on_low_o(bon),
    .standby_low_o(sby), .chip_clear_low_o(clr), .dir_o(dir),
    .microstep_sel0_o(ms0), .microstep_sel1_o(ms1),
    .sync_rectify_low_o(srl), .step_o(step));

  ssp_drv_model drv (.bridge_on_low_i(bon), .standby_low_i(sby),
    .chip_clear_low_i(clr), .dir_i(dir), .sync_rectify_low_i(srl),
    .step_i(step), .steps_o(steps), .position_o(pos), .faults_o(faults));

  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // the run is a few thousand cycles; this ceiling only cuts a hang
  always @(posedge mclk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      miscompares++;
      give_verdict;
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe edge
  task rd(input logic [7:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task do_reset;
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    #1;
    chk("pins after reset", 32'h41, {24'h0, pins});
  endtask

  // polls the rate; every change must be one increment, clamped at the target or floor, one time base apart
  task automatic watch(input int n, input logic up, input logic [15:0] acc,
    input logic [15:0] tgt);
    logic [15:0] prev, e;
    int t, last, c;
    rd(STATUS_OFF);
    prev = d[31:16];
    t = 0;
    last = 0;
    c = 0;
    while (c < n && t < 800)
    begin
      rd(STATUS_OFF);
      t += 2;
      if (d[31:16] !== prev)
      begin
        if (up)
          e = (prev + acc > tgt) ? tgt : prev + acc;
        else
          e = (prev <= MIN_RATE + acc) ? MIN_RATE : prev - acc;
        chk("rate step", {16'h0, e}, {16'h0, d[31:16]});
        if (c > 0)
          chk("rate spacing", 1, 32'(t - last >= TB * MSC - 2 &&
            t - last <= TB * MSC + 2));
        last = t;
        prev = d[31:16];
        c++;
      end
    end
    chk("rate changes seen", n, c);
  endtask

  initial
  begin
    do_reset;
    for (int i = 0; i < 8; i++)
      if (i != 6)
      begin
        rd(8'(4 * i));
        chk("reset value", RV[i], d);
      end
    ctrl = CTRL_RST;
    for (int i = 0; i < 10; i++)
    begin
      wr(RA[i], RD[i]);
      if (RA[i] == CTRL_OFF)
        ctrl = RD[i][7:0];
      rd(RA[i]);
      chk("register readback", RE[i], d);
      chk("control pins", {24'h0, ctrl}, {24'h0, pins});
    end
    chk("manual step seen", 1, steps);
    // continuous run with a ramp
    wr(CTRL_OFF, 32'h06);
    wr(TARGET_OFF, 32'd100);
    wr(ACCEL_OFF, 32'd10);
    wr(TBASE_OFF, TB);
    wr(CMD_OFF, 32'h1);
    repeat (2) @(posedge mclk_i);
    #1;
    chk("run first step", 1, {31'h0, step});
    rd(STATUS_OFF);
    chk("run start", {16'd62, 16'h1}, d);
    watch(3, 1'b1, 16'd10, 16'd100);
    repeat (120) @(posedge mclk_i);
    rd(STATUS_OFF);
    chk("rate held", 100, {16'h0, d[31:16]});
    wr(TARGET_OFF, 32'd130);
    wr(CMD_OFF, 32'h8);
    watch(2, 1'b1, 16'd10, 16'd130);
    repeat (120) @(posedge mclk_i);
    rd(STATUS_OFF);
    chk("updated rate", {16'd130, 16'h1}, d);
    wr(CMD_OFF, 32'h1);
    rd(STATUS_OFF);
    chk("stopping state", 2, {29'h0, d[2:0]});
    wr(TARGET_OFF, 32'd300);
    wr(CMD_OFF, 32'h8);
    watch(5, 1'b0, 16'd10, 16'd62);
    repeat (120) @(posedge mclk_i);
    rd(STATUS_OFF);
    chk("stop rate floor", 62, {16'h0, d[31:16]});
    do_reset;
    // counted move at constant rate
    wr(CTRL_OFF, 32'h06);
    wr(TARGET_OFF, 32'd40000);
    wr(COUNT_OFF, 32'd0);
    base = steps;
    wr(CMD_OFF, 32'h4);
    repeat (40) @(posedge mclk_i);
    rd(STATUS_OFF);
    chk("empty move state", 0, {29'h0, d[2:0]});
    chk("empty move steps", base, steps);
    wr(COUNT_OFF, 32'd3);
    wr(CMD_OFF, 32'h4);
    k = 0;
    while (step !== 1'b1 && k < 200)
    begin
      @(posedge mclk_i);
      #1;
      k++;
    end
    for (int p = 0; p < 3; p++)
    begin
      hi = 0;
      per = 0;
      while (step === 1'b1 && hi < 3000)
      begin
        @(posedge mclk_i);
        #1;
        hi++;
        per++;
      end
      chk("move high time", (CLK_HZ / 40000 + 1) / 2, hi);
      if (p < 2)
      begin
        while (step !== 1'b1 && per < 3000)
        begin
          @(posedge mclk_i);
          #1;
          per++;
        end
        chk("move period", CLK_HZ / 40000, per);
      end
    end
    k = 0;
    d = 32'hFF;
    while (d[2:0] !== 3'h0 && k < 1000)
    begin
      rd(STATUS_OFF);
      k++;
    end
    chk("move pulse count", base + 3, steps);
    rd(REMAIN_OFF);
    chk("move remaining", 0, d);
    chk("move position", 32'hFFFF_FFFD, pos);
    // single step
    base = steps;
    wr(CMD_OFF, 32'h2);
    repeat (2) @(posedge mclk_i);
    #1;
    chk("single step line", 1, {31'h0, step});
    repeat (200) @(posedge mclk_i);
    rd(STATUS_OFF);
    chk("single step busy", 3, {29'h0, d[2:0]});
    chk("single step count", base + 1, steps);
    // clock enable low: a write in that window must not land
    @(posedge mclk_i);
    ce_i <= 1'b0;
    wr(CTRL_OFF, 32'h0000_00BE);
    ce_i <= 1'b1;
    rd(CTRL_OFF);
    chk("frozen control write", 32'h06, d);
    chk("rectify faults", 0, faults);
    give_verdict;
  end
endmodule // ssp_profiler_bench
